// ===== include/alp_cfg.svh
// alp_cfg.svh : offsets, field positions, reset values and timing counts
`ifndef ALP_CFG_SVH
`define ALP_CFG_SVH

// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define ALP_MCLK_MHZ        20

// ---------------------------------------------------------------
// register map and fields
// ---------------------------------------------------------------
`define ALP_UNLOCK_ADDR     8'h05
`define ALP_UNLOCK_KEY      8'h69
`define ALP_PWRCTL_ADDR     8'h04
`define ALP_DEEP_BIT        0
`define ALP_LIGHT_BIT       1
`define ALP_PWRCTL_RST      8'h00

// ---------------------------------------------------------------
// times in ns and derived cycle counts
// ---------------------------------------------------------------
`define ALP_CONV_NS         1000
`define ALP_WAKE_NS         2000
`define ALP_PWRUP_NS        100000
// conversion length is a fixed duration, rounded down
`define ALP_CONV_CYC  ((`ALP_CONV_NS * `ALP_MCLK_MHZ) / 1000)
// least times, rounded up
`define ALP_WAKE_CYC  ((`ALP_WAKE_NS * `ALP_MCLK_MHZ + 999) / 1000)
`define ALP_PWRUP_CYC ((`ALP_PWRUP_NS * `ALP_MCLK_MHZ + 999) / 1000)
// extra high time the host keeps past the conversion (sync latency)
`define ALP_HOST_MARGIN     8
`define ALP_CNT_W           12

`endif

// ===== include/alp_pkg.sv
// alp_pkg.sv : state types shared by both ends
package alp_pkg;

  // ---------------------------------------------------------------
  // device power modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ALP_D_ACQ,
    ALP_D_CONV,
    ALP_D_LIGHT,
    ALP_D_DEEP,
    ALP_D_PWRUP
  } alp_dev_state_t;

  // ---------------------------------------------------------------
  // host sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ALP_H_IDLE,
    ALP_H_KEY,
    ALP_H_CTL,
    ALP_H_HIGH,
    ALP_H_HOLD
  } alp_host_state_t;

endpackage : alp_pkg

// ===== include/alp_link_if.sv
// alp_link_if.sv : pins between host controller and converter
`timescale 1ns/1ps
interface alp_link_if;
  logic       convert_start_select; // host driven start / select pin
  logic       ready_indicator;      // device driven ready pin
  logic       wr_valid;             // one-cycle register write strobe
  logic [7:0] wr_addr;              // register address of the write
  logic [7:0] wr_data;              // data of the write

  modport dev (
    input  convert_start_select,
    input  wr_valid,
    input  wr_addr,
    input  wr_data,
    output ready_indicator
  );

  modport host (
    output convert_start_select,
    output wr_valid,
    output wr_addr,
    output wr_data,
    input  ready_indicator
  );
endinterface : alp_link_if

// ===== core/alp_host.sv
// alp_host.sv : host controller end, sequences unlock, writes, starts
`timescale 1ns/1ps
`include "alp_cfg.svh"
module alp_host (
  input  wire logic mclk,
  input  wire logic nrst,
  alp_link_if.host  link,
  input  wire logic cfg_req,      // pulse: write power control
  input  wire logic cfg_light,    // light sleep enable to write
  input  wire logic cfg_deep,     // deep sleep request to write
  input  wire logic conv_req,     // pulse: start or wake
  input  wire logic conv_hold,    // keep select high after convert
  output logic      busy,         // requests ignored while high, except conv_req in ALP_H_HOLD
  output logic      ready_seen    // synchronised ready pin
);
  import alp_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  alp_host_state_t           state;
  logic [`ALP_CNT_W-1:0]     cnt;        // high-time counter
  logic [`ALP_CNT_W-1:0]     guard;      // least wait before next rise
  logic                      deep_set;   // deep bit as last written
  logic [7:0]                ctl_val;    // value for the control write
  logic                      rs1;        // sync stage 1
  logic                      rs2;        // sync stage 2
  logic                      rs3;        // sync stage 3

  assign busy = (state != ALP_H_IDLE) || (guard != '0);

  // ---------------------------------------------------------------
  // ready pin: three flops, accept once stages 2 and 3 agree
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rs1        <= 1'b0;
      rs2        <= 1'b0;
      rs3        <= 1'b0;
      ready_seen <= 1'b0;
    end else begin
      rs1 <= link.ready_indicator;
      rs2 <= rs1;
      rs3 <= rs2;
      if (rs2 == rs3) begin
        ready_seen <= rs3;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state                     <= ALP_H_IDLE;
      cnt                       <= '0;
      guard                     <= '0;
      deep_set                  <= 1'b0;
      ctl_val                   <= `ALP_PWRCTL_RST;
      link.convert_start_select <= 1'b0;
      link.wr_valid             <= 1'b0;
      link.wr_addr              <= 8'h00;
      link.wr_data              <= 8'h00;
    end else begin
      link.wr_valid <= 1'b0;
      if (guard != '0) begin
        guard <= guard - 1'b1;
      end
      case (state)
        ALP_H_IDLE: begin
          if (guard == '0 && cfg_req) begin
            // key first, else the control write is dropped
            link.wr_valid         <= 1'b1;
            link.wr_addr          <= `ALP_UNLOCK_ADDR;
            link.wr_data          <= `ALP_UNLOCK_KEY;
            ctl_val               <= 8'h00;
            ctl_val[`ALP_LIGHT_BIT] <= cfg_light;
            ctl_val[`ALP_DEEP_BIT]  <= cfg_deep;
            state                 <= ALP_H_KEY;
          end else if (guard == '0 && conv_req) begin
            link.convert_start_select <= 1'b1;
            cnt   <= `ALP_CNT_W'(`ALP_CONV_CYC + `ALP_HOST_MARGIN);
            state <= ALP_H_HIGH;
          end
        end
        ALP_H_KEY: begin
          link.wr_valid <= 1'b1;
          link.wr_addr  <= `ALP_PWRCTL_ADDR;
          link.wr_data  <= ctl_val;
          state         <= ALP_H_CTL;
        end
        ALP_H_CTL: begin
          deep_set <= ctl_val[`ALP_DEEP_BIT];
          if (deep_set && !ctl_val[`ALP_DEEP_BIT]) begin
            // leaving deep sleep: no start until power-up is over
            guard <= `ALP_CNT_W'(`ALP_PWRUP_CYC);
          end
          state <= ALP_H_IDLE;
        end
        ALP_H_HIGH: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (conv_hold) begin
            state <= ALP_H_HOLD; // select stays high for light sleep
          end else begin
            link.convert_start_select <= 1'b0;
            if (ctl_val[`ALP_LIGHT_BIT]) begin
              // light sleep may have been entered anyway; this fall
              // wakes it, so the next rise waits out the wake time
              guard <= `ALP_CNT_W'(`ALP_WAKE_CYC);
            end
            state <= ALP_H_IDLE;
          end
        end
        ALP_H_HOLD: begin
          if (conv_req) begin
            // falling edge wakes; the rise waits for the wake time
            link.convert_start_select <= 1'b0;
            guard <= `ALP_CNT_W'(`ALP_WAKE_CYC);
            state <= ALP_H_IDLE;
          end
        end
        default: begin
          state <= ALP_H_IDLE;
        end
      endcase
    end
  end
endmodule : alp_host

// ===== core/alp_device.sv
// alp_device.sv : converter end, power control register and power modes
`timescale 1ns/1ps
`include "alp_cfg.svh"
// Operation
// - normal mode keeps all blocks powered
// - host writes key to unlock address first
// - light enable, select high: enter light sleep
// - light sleep reduces power during acquisition
// - select falling edge ends light sleep
// - host waits wake time before next rise
// - deep bit set: next rise enters deep
// - deep: analog off, interface and registers kept
// - ready pin high while in deep sleep
// - clearing deep bit starts power-up, ready high
// - host waits power-up time before converting
module alp_device (
  input  wire logic              mclk,
  input  wire logic              nrst,
  alp_link_if.dev                link,
  output logic                   light_sleep_enable, // control bit
  output logic                   deep_sleep_request, // control bit
  output logic                   unlocked,           // key accepted
  output alp_pkg::alp_dev_state_t power_mode,       // current mode
  output logic                   analog_power_on,    // analog supplied
  output logic                   reduced_power,      // low-power bias
  output logic                   conv_done           // end of convert
);
  import alp_pkg::*;

  // ---------------------------------------------------------------
  // select pin synchroniser and edge detection
  // ---------------------------------------------------------------
  logic                  cs1;        // stage 1, read by stage 2 only
  logic                  cs2;        // stage 2
  logic                  cs3;        // stage 3
  logic                  cs_level;   // accepted pin level
  logic                  cs_prev;    // accepted level one cycle ago
  logic                  cs_rise;    // accepted rising edge
  logic                  cs_fall;    // accepted falling edge
  logic [`ALP_CNT_W-1:0] cnt;        // conversion / power-up counter
  logic                  ready_q;    // registered ready pin

  // three flops; a change counts once stages 2 and 3 agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs1      <= 1'b0;
      cs2      <= 1'b0;
      cs3      <= 1'b0;
      cs_level <= 1'b0;
      cs_prev  <= 1'b0;
    end else begin
      cs1     <= link.convert_start_select;
      cs2     <= cs1;
      cs3     <= cs2;
      cs_prev <= cs_level;
      if (cs2 == cs3) begin
        cs_level <= cs3;
      end
    end
  end

  // edges come from the accepted level, so a glitch shorter than
  // two cycles never reaches the mode sequencer
  assign cs_rise = cs_level && !cs_prev;
  assign cs_fall = !cs_level && cs_prev;

  // ---------------------------------------------------------------
  // power control register with unlock key
  // ---------------------------------------------------------------
  // reset image kept as an eight-bit constant so each field can be
  // picked by position instead of narrowed by a shift
  localparam logic [7:0] pwrctl_rst = `ALP_PWRCTL_RST;

  logic                  key_wr;     // write aimed at the unlock address
  logic                  ctl_wr;     // write aimed at the control address

  // address decode of the one-cycle write strobe
  assign key_wr = link.wr_valid && (link.wr_addr == `ALP_UNLOCK_ADDR);
  assign ctl_wr = link.wr_valid && (link.wr_addr == `ALP_PWRCTL_ADDR);

  // the key arms one control write only; a stray write after it
  // must be keyed again, which keeps a runaway host from sleeping us
  // writes to other addresses leave the armed key as it is
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unlocked <= 1'b0;
    end else if (key_wr) begin
      // a wrong key disarms as well, not only the right one arms
      unlocked <= (link.wr_data == `ALP_UNLOCK_KEY);
    end else if (ctl_wr) begin
      unlocked <= 1'b0; // spent, whether or not the write landed
    end
  end

  // control bits; served in every mode, deep sleep included
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      light_sleep_enable <= pwrctl_rst[`ALP_LIGHT_BIT];
      deep_sleep_request <= pwrctl_rst[`ALP_DEEP_BIT];
    end else if (ctl_wr && unlocked) begin
      light_sleep_enable <= link.wr_data[`ALP_LIGHT_BIT];
      deep_sleep_request <= link.wr_data[`ALP_DEEP_BIT];
    end
    // an unkeyed control write falls through and changes nothing
  end

  // ---------------------------------------------------------------
  // power mode sequencer
  // ---------------------------------------------------------------
  // writes are served in every mode, so deep sleep never blocks
  // the interface and the register keeps its value throughout
  // the counter is shared by conversion and power-up, which never
  // overlap, so one down-counter serves both
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_mode <= ALP_D_ACQ;
      cnt        <= '0;
      conv_done  <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (power_mode)
        ALP_D_ACQ: begin
          // a rise starts work; the deep bit decides which kind
          if (cs_rise && deep_sleep_request) begin
            // no conversion on this edge, straight to deep sleep
            power_mode <= ALP_D_DEEP;
          end else if (cs_rise) begin
            // counter holds the cycles left after this one
            cnt        <= `ALP_CNT_W'(`ALP_CONV_CYC - 1);
            power_mode <= ALP_D_CONV;
          end
          // a fall here is only the tail of the last frame
        end
        ALP_D_CONV: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            conv_done <= 1'b1;
            // the level is sampled only at the end of conversion
            if (light_sleep_enable && cs_level) begin
              power_mode <= ALP_D_LIGHT;
            end else begin
              power_mode <= ALP_D_ACQ;
            end
          end
        end
        ALP_D_LIGHT: begin
          // a rise cannot arrive here, the pin is already high
          if (cs_fall) begin
            power_mode <= ALP_D_ACQ;
          end
        end
        ALP_D_DEEP: begin
          // select edges are ignored; only the cleared bit wakes us
          if (!deep_sleep_request) begin
            cnt        <= `ALP_CNT_W'(`ALP_PWRUP_CYC - 1);
            power_mode <= ALP_D_PWRUP;
          end
        end
        ALP_D_PWRUP: begin
          // select edges here are ignored; host must wait it out
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            power_mode <= ALP_D_ACQ;
          end
        end
        default: begin
          power_mode <= ALP_D_ACQ;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power enables and ready pin, all registered
  // ---------------------------------------------------------------
  // each output follows the mode one cycle late; the lag keeps the
  // pins free of decode glitches at the cost of one cycle of latency

  // analog supply: on in acquisition, conversion and light sleep, so no
  // block is powered down between conversions outside deep and power-up
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      analog_power_on <= 1'b1; // powered from reset on
    end else begin
      analog_power_on <= (power_mode != ALP_D_DEEP) &&
                         (power_mode != ALP_D_PWRUP);
    end
  end

  // low-power bias only while napping in the acquisition phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reduced_power <= 1'b0; // full bias after reset
    end else begin
      reduced_power <= (power_mode == ALP_D_LIGHT);
    end
  end

  // ready low only while converting; high in deep and power-up
  // alike, so the host may write at any time outside a conversion
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ready_q <= 1'b1; // ready from reset on
    end else begin
      ready_q <= (power_mode != ALP_D_CONV);
    end
  end

  assign link.ready_indicator = ready_q;

endmodule : alp_device

// ===== dv/alp_checker.sv
// alp_checker.sv : timing checks on the host to converter link
`timescale 1ns/1ps
`include "alp_cfg.svh"
module alp_checker (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       convert_start_select,
  input wire logic       ready_indicator,
  input wire logic       wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data
);
  // ---------------------------------------------------------------
  // shadows rebuilt from the wire
  // ---------------------------------------------------------------
  logic                  key_q;    // last cycle carried the key
  logic                  deep_sh;  // deep request as last written
  logic                  light_sh; // light enable as last written
  logic [`ALP_CNT_W-1:0] low_cnt;  // run length of ready low
  logic [`ALP_CNT_W-1:0] wake_cnt; // host wait after a light wake
  logic [`ALP_CNT_W-1:0] up_cnt;   // host wait after deep exit
  wire ctl_wr = wr_valid && wr_addr == `ALP_PWRCTL_ADDR && key_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // key and control shadow, only armed writes count
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      key_q    <= 1'b0;
      deep_sh  <= 1'b0;
      light_sh <= 1'b0;
    end else begin
      key_q <= wr_valid && wr_addr == `ALP_UNLOCK_ADDR
               && wr_data == `ALP_UNLOCK_KEY;
      if (ctl_wr) begin
        deep_sh  <= wr_data[`ALP_DEEP_BIT];
        light_sh <= wr_data[`ALP_LIGHT_BIT];
      end
    end
  end

  // ready low run, cleared whenever ready is high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) low_cnt <= '0;
    else if (ready_indicator) low_cnt <= '0;
    else low_cnt <= low_cnt + 1'b1;
  end

  // guard windows; loaded a little short so latency never trips them
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt <= '0;
      up_cnt   <= '0;
    end else begin
      if (light_sh && $fell(convert_start_select))
        wake_cnt <= `ALP_CNT_W'(`ALP_WAKE_CYC - 2);
      else if (wake_cnt != 0) wake_cnt <= wake_cnt - 1'b1;
      if (ctl_wr && deep_sh && !wr_data[`ALP_DEEP_BIT])
        up_cnt <= `ALP_CNT_W'(`ALP_PWRUP_CYC - 8);
      else if (up_cnt != 0) up_cnt <= up_cnt - 1'b1;
    end
  end

  a_key_value: assert property (wr_valid
    && wr_addr == `ALP_UNLOCK_ADDR |-> wr_data == `ALP_UNLOCK_KEY)
    else $error("wrong unlock key");
  a_key_before_ctl: assert property (wr_valid
    && wr_addr == `ALP_PWRCTL_ADDR |-> key_q) else $error("ctl not keyed");
  a_conv_length: assert property ($rose(ready_indicator)
    |-> low_cnt == `ALP_CONV_CYC) else $error("conversion length off");
  a_conv_cause: assert property ($fell(ready_indicator)
    |-> convert_start_select && $past(convert_start_select, 3))
    else $error("conversion without start");
  a_light_holds: assert property ($rose(ready_indicator)
    && convert_start_select && light_sh |-> ready_indicator[*8])
    else $error("light sleep converted");
  a_wake_wait: assert property ($rose(convert_start_select)
    |-> wake_cnt == 0) else $error("start inside wake time");
  a_exit_wait: assert property ($rose(convert_start_select)
    |-> up_cnt == 0) else $error("start inside power-up time");
  a_deep_ready: assert property (deep_sh
    && $rose(convert_start_select) |-> ready_indicator[*8])
    else $error("deep not ready");
  a_exit_ready: assert property (ctl_wr && deep_sh
    && !wr_data[`ALP_DEEP_BIT] |=> ready_indicator[*8])
    else $error("power-up ready low");
endmodule : alp_checker

// ===== dv/adc_low_power_mode_control_tb_top.sv
// adc_low_power_mode_control_tb_top.sv : self-checking bench, both ends
`timescale 1ns/1ps
`include "alp_cfg.svh"
module adc_low_power_mode_control_tb_top;
  import alp_pkg::*;
  logic           mclk, nrst, busy, ready_seen;   // clock, reset, host
  logic           cfg_req, cfg_light, cfg_deep;   // host config inputs
  logic           conv_req, conv_hold;            // host start inputs
  logic           lse, dsr, unl, ana, red, cdone; // device outputs
  logic           lse2, dsr2, unl2;               // fault-side bits
  alp_dev_state_t mode;                           // device power mode
  int             n_errors = 0;
  int             n_checks = 0;

  alp_link_if link_a();
  alp_link_if link_b(); // driven raw by the bench to break the order
  alp_host alp_host_i (.mclk(mclk), .nrst(nrst), .link(link_a),
    .cfg_req(cfg_req), .cfg_light(cfg_light), .cfg_deep(cfg_deep),
    .conv_req(conv_req), .conv_hold(conv_hold), .busy(busy),
    .ready_seen(ready_seen));
  alp_device alp_device_i (.mclk(mclk), .nrst(nrst), .link(link_a),
    .light_sleep_enable(lse), .deep_sleep_request(dsr), .unlocked(unl),
    .power_mode(mode), .analog_power_on(ana), .reduced_power(red),
    .conv_done(cdone));
  alp_device alp_device_fault_i (.mclk(mclk), .nrst(nrst), .link(link_b),
    .light_sleep_enable(lse2), .deep_sleep_request(dsr2), .unlocked(unl2),
    .power_mode(), .analog_power_on(), .reduced_power(), .conv_done());
  alp_checker alp_checker_i (.mclk(mclk), .nrst(nrst),
    .convert_start_select(link_a.convert_start_select),
    .ready_indicator(link_a.ready_indicator), .wr_valid(link_a.wr_valid),
    .wr_addr(link_a.wr_addr), .wr_data(link_a.wr_data));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_mode(input alp_dev_state_t got, alp_dev_state_t exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_mode

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // bounded wait for the host to go idle; a hang ends the run
  task automatic wait_idle(output int cyc);
    cyc = 0;
    while (busy !== 1'b0) begin
      tick(1);
      cyc++;
      if (cyc > 5000) begin
        n_errors++;
        final_report();
      end
    end
  endtask : wait_idle

  // poll for a mode, then judge it (a miss shows as a mismatch)
  task automatic wait_mode(input alp_dev_state_t m);
    for (int i = 0; i < 100 && mode !== m; i++) tick(1);
    chk_mode(mode, m);
  endtask : wait_mode

  task automatic host_cfg(input logic l, input logic d);
    cfg_light = l;
    cfg_deep  = d;
    cfg_req   = 1'b1;
    tick(1);
    cfg_req = 1'b0;
    tick(4);
  endtask : host_cfg

  task automatic start(input logic hold);
    conv_hold = hold;
    conv_req  = 1'b1;
    tick(1);
    conv_req = 1'b0;
  endtask : start

  task automatic wait_done;
    for (int i = 0; i < 200 && cdone !== 1'b1; i++) tick(1);
    chk_bit(cdone, 1'b1);
  endtask : wait_done

  task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
    link_b.wr_addr  = a;
    link_b.wr_data  = d;
    link_b.wr_valid = 1'b1;
    tick(1);
    link_b.wr_valid = 1'b0;
    tick(1);
  endtask : wr_raw

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk_mode(mode, ALP_D_ACQ);
    chk_bit(ana, 1'b1);
    chk_bit(link_a.ready_indicator, 1'b1);
    chk_bit(lse, 1'b0);
    chk_bit(dsr, 1'b0);
  endtask : t_reset

  // unkeyed, wrong-key and re-used-key writes must all be dropped,
  // and a write to another address must not spend the key
  task automatic t_locked;
    wr_raw(8'h04, 8'h03);
    chk_bit(lse2, 1'b0);
    wr_raw(8'h05, 8'h69);
    chk_bit(unl2, 1'b1);
    wr_raw(8'h04, 8'h03);
    chk_bit(dsr2, 1'b1);
    chk_bit(unl2, 1'b0);
    wr_raw(8'h04, 8'h00);
    chk_bit(lse2, 1'b1);
    wr_raw(8'h05, 8'h68);
    wr_raw(8'h04, 8'h00);
    chk_bit(dsr2, 1'b1);
    wr_raw(8'h05, 8'h69);
    wr_raw(8'h10, 8'h00);
    chk_bit(unl2, 1'b1);
    wr_raw(8'h04, 8'h00);
    chk_bit(dsr2, 1'b0);
  endtask : t_locked

  task automatic t_normal;
    int c;
    start(1'b0);
    wait_done();
    chk_bit(ready_seen, 1'b0);
    tick(2);
    chk_mode(mode, ALP_D_ACQ);
    chk_bit(ana, 1'b1);
    wait_idle(c);
  endtask : t_normal

  task automatic t_light;
    int c;
    host_cfg(1'b1, 1'b0);
    wait_idle(c);
    chk_bit(lse, 1'b1);
    chk_bit(unl, 1'b0);
    start(1'b1);
    wait_done();
    wait_mode(ALP_D_LIGHT);
    tick(2);
    chk_bit(red, 1'b1);
    tick(40);
    chk_mode(mode, ALP_D_LIGHT);
    start(1'b0);
    wait_mode(ALP_D_ACQ);
    tick(2);
    chk_bit(red, 1'b0);
    wait_idle(c);
  endtask : t_light

  task automatic t_deep;
    int c;
    host_cfg(1'b1, 1'b1);
    wait_idle(c);
    start(1'b0);
    wait_mode(ALP_D_DEEP);
    tick(2);
    chk_bit(ana, 1'b0);
    chk_bit(lse, 1'b1);
    chk_bit(link_a.ready_indicator, 1'b1);
    chk_bit(ready_seen, 1'b1);
    wait_idle(c);
    host_cfg(1'b1, 1'b0);
    chk_mode(mode, ALP_D_PWRUP);
    chk_bit(link_a.ready_indicator, 1'b1);
    wait_idle(c);
    chk_bit(c >= `ALP_PWRUP_CYC - 8, 1'b1);
    wait_mode(ALP_D_ACQ);
    start(1'b0);
    wait_done();
  endtask : t_deep

  initial begin
    nrst = 1'b0;
    {cfg_req, cfg_light, cfg_deep, conv_req, conv_hold} = '0;
    link_b.convert_start_select = 1'b0;
    link_b.wr_valid = 1'b0;
    link_b.wr_addr  = 8'h00;
    link_b.wr_data  = 8'h00;
    repeat (3) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    tick(1);
    t_reset();
    t_locked();
    t_normal();
    t_light();
    t_deep();
    final_report();
  end

  // overall limit against a hang anywhere
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule : adc_low_power_mode_control_tb_top
